// File: verilog/audio_clock_pkg.sv
/*
 * Constants, field layouts and carrier types of the audio clock
 * generator and cleaner. Assumes nothing of its surroundings.
 */
// Operation
// - Frame-sync period is 64 or 32 bit clocks
// - Master-to-bit ratio codes give 4,2,1,8
// - Cleaner source is VCO/8,/4,/2 or oscillator
// - Nonzero clean mode cleans clock, ratios 1,2,4
// - Direction bit drives pins and enables generation
// - 24-bit time stamp regenerates clock when it and the divisor are nonzero
// - 20-bit divisor used with time stamp
// - Feedback divided by two to filter_shift
// - Input FIFO fill readable at bits 5:3
// - Output FIFO fill readable at bits 2:0
`default_nettype none

package audio_clock_pkg;

  // Register offsets on the serial control bus
  localparam logic [7:0] ADDR_CTRL     = 8'h30;
  localparam logic [7:0] ADDR_CTS_LOW  = 8'h31;
  localparam logic [7:0] ADDR_CTS_MID  = 8'h32;
  localparam logic [7:0] ADDR_CTS_HIGH = 8'h33;
  localparam logic [7:0] ADDR_DIV_LOW  = 8'h34;
  localparam logic [7:0] ADDR_DIV_MID  = 8'h35;
  localparam logic [7:0] ADDR_DIV_HIGH = 8'h36;
  localparam logic [7:0] ADDR_LEVELS   = 8'h37;

  // Reset values
  localparam logic [7:0]  RESET_BYTE   = 8'h00;
  localparam logic [15:0] PERIOD_RESET = 16'h0010;

  // Field positions
  localparam int FILTER_SHIFT_LSB = 4;
  localparam int DIV_HIGH_LSB     = 0;
  localparam int INPUT_FILL_LSB   = 3;
  localparam int OUTPUT_FILL_LSB  = 0;

  // Fill counters saturate at the top of their three bits
  localparam logic [2:0] FILL_MAX = 3'h7;

  // Last bit clock period count in each frame-sync half-period
  localparam logic [5:0] HALF_FRAME_64 = 6'h1F;
  localparam logic [5:0] HALF_FRAME_32 = 6'h0F;

  // Control byte, bit 7 down to bit 0
  typedef struct packed {
    logic       frame_32;
    logic [1:0] mclk_ratio;
    logic [1:0] clean_div;
    logic [1:0] clean_mode;
    logic       master;
  } audio_ctrl_t;

  typedef struct packed {
    logic [2:0] input_fill;
    logic [2:0] output_fill;
  } cleaner_fill_t;

endpackage

`default_nettype wire

// File: verilog/clock_cleaner.sv
/*
 * Digital clock cleaner: tracks the spacing of raw clock events in
 * reference ticks, smooths it and replays evenly spaced events.
 * Assumes both tick inputs are single-cycle pulses on core_clk.
 */
`default_nettype none

module clock_cleaner (
  input  wire logic                          core_clk,
  input  wire logic                          reset_n,
  input  wire logic                          source_tick,
  input  wire logic                          raw_tick,
  input  wire logic [1:0]                    clean_mode,
  input  wire logic [3:0]                    filter_shift,
  output logic                               clean_tick,
  output audio_clock_pkg::cleaner_fill_t     fill
);

  logic [15:0] interval;
  logic [15:0] period;
  logic [15:0] phase;
  logic [2:0]  in_fill;
  logic [2:0]  out_fill;
  logic [15:0] next_interval;
  logic [15:0] next_period;
  logic [15:0] next_phase;
  logic [2:0]  next_in_fill;
  logic [2:0]  next_out_fill;
  logic        fire;
  logic [15:0] target;
  logic signed [16:0] error;

  // Drain one stored event per reference tick
  assign clean_tick = (clean_mode != 2'b00) && source_tick
                      && (out_fill != 3'h0);
  // One driver for the whole fill word
  assign fill = {in_fill, out_fill};

  // Higher ratios shorten the replay period
  always_comb begin
    target = period >> (clean_mode - 2'b01);
    if (target == 16'h0000) begin
      target = 16'h0001;
    end
    fire  = source_tick && (phase + 16'h0001 >= target)
            && (in_fill != 3'h0);
    error = $signed({1'b0, interval}) - $signed({1'b0, period});
  end

  // Tracking loop and the two fill counters
  always_comb begin
    next_interval = interval;
    next_period   = period;
    next_phase    = phase;
    next_in_fill  = in_fill;
    next_out_fill = out_fill;
    if (clean_mode == 2'b00) begin
      next_interval = 16'h0000;
      next_period   = audio_clock_pkg::PERIOD_RESET;
      next_phase    = 16'h0000;
      next_in_fill  = 3'h0;
      next_out_fill = 3'h0;
    end else begin
      if (raw_tick) begin
        // Shift keeps jitter out of the period estimate
        next_period   = 16'(period + 16'(error >>> filter_shift));
        next_interval = 16'h0000;
      end else if (source_tick && interval != 16'hFFFF) begin
        next_interval = 16'(interval + 16'h0001);
      end
      if (fire) begin
        next_phase = 16'h0000;
      end else if (source_tick) begin
        next_phase = 16'(phase + 16'h0001);
      end
      // Saturating levels; overflow beyond seven is dropped
      if (raw_tick && !fire && in_fill != audio_clock_pkg::FILL_MAX) begin
        next_in_fill = 3'(in_fill + 3'h1);
      end else if (fire && !raw_tick) begin
        next_in_fill = 3'(in_fill - 3'h1);
      end
      if (fire && !clean_tick
          && out_fill != audio_clock_pkg::FILL_MAX) begin
        next_out_fill = 3'(out_fill + 3'h1);
      end else if (clean_tick && !fire) begin
        next_out_fill = 3'(out_fill - 3'h1);
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      interval <= 16'h0000;
      period   <= audio_clock_pkg::PERIOD_RESET;
      phase    <= 16'h0000;
      in_fill  <= 3'h0;
      out_fill <= 3'h0;
    end else begin
      interval <= next_interval;
      period   <= next_period;
      phase    <= next_phase;
      in_fill  <= next_in_fill;
      out_fill <= next_out_fill;
    end
  end

  // Cleaner idle when switched off
  a_clean_off_idle: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    (clean_mode == 2'b00) |=> (in_fill == 3'h0 && out_fill == 3'h0)
    && !clean_tick)
    else $error("cleaner active while off");

  // Period follows shifted error on each raw event
  a_period_shift_step: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    (clean_mode != 2'b00 && raw_tick)
    |=> period == 16'($past(period)
                       + 16'($past(error) >>> $past(filter_shift))))
    else $error("period did not follow filtered error");

  // Input fill rises on an undrained raw event
  a_input_fill_rise: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    (clean_mode != 2'b00 && raw_tick && !fire && in_fill < 3'h7)
    |=> in_fill == $past(in_fill) + 3'h1)
    else $error("input fill did not count raw event");

  // Output fill falls when an event is drained
  a_output_fill_fall: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    (clean_tick && !fire) |=> out_fill == $past(out_fill) - 3'h1)
    else $error("output fill did not count drain");

endmodule // clock_cleaner

`default_nettype wire

// File: verilog/audio_clock_generator_cleaner.sv
/*
 * Audio clock generator and cleaner: control registers, cleaner
 * reference selection, time-stamp clock regeneration and the master,
 * bit and frame-sync clock dividers. Assumes a register port on
 * core_clk with one-cycle strobes, and VCO, oscillator and pin inputs
 * from other domains, all much slower than core_clk.
 */
`default_nettype none

module audio_clock_generator_cleaner (
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic [7:0]       reg_rdata,
  output logic             reg_rdata_valid,
  input  wire logic        link_pll_vco_clock,
  input  wire logic        always_on_oscillator,
  input  wire logic        bit_clock_in,
  output logic             bit_clock_out,
  output logic             bit_clock_oe_n,
  input  wire logic        frame_sync_pin_in,
  output logic             frame_sync_pin_out,
  output logic             frame_sync_pin_oe_n,
  output logic             audio_master_clock,
  output logic             received_frame_sync
);

  audio_clock_pkg::audio_ctrl_t   ctrl;
  audio_clock_pkg::audio_ctrl_t   next_ctrl;
  audio_clock_pkg::cleaner_fill_t fill;
  audio_clock_pkg::cleaner_fill_t fill_held;
  logic [23:0] cts;
  logic [23:0] next_cts;
  logic [7:0]  div_high;
  logic [7:0]  next_div_high;
  logic [15:0] div_low;
  logic [15:0] next_div_low;
  logic [7:0]  next_rdata;
  logic [19:0] divisor;
  logic [3:0]  filter_shift;
  logic [3:0]  sync_first;
  logic [3:0]  sync_second;
  logic [3:0]  sync_prev;
  logic [3:0]  pin_edge;
  logic        vco_edge;
  logic        osc_edge;
  logic        bclk_edge;
  logic [2:0]  div_count;
  logic [2:0]  next_div_count;
  logic [2:0]  div_limit;
  logic        source_tick;
  logic [24:0] acc;
  logic [24:0] next_acc;
  logic [24:0] acc_sum;
  logic        regen_on;
  logic        regen_tick;
  logic        next_regen_tick;
  logic        raw_tick;
  logic        clean_tick;
  logic        mclk_tick;
  logic [2:0]  mclk_count;
  logic [2:0]  next_mclk_count;
  logic [2:0]  mclk_limit;
  logic [5:0]  bit_count;
  logic [5:0]  next_bit_count;
  logic [5:0]  half_frame;
  logic        next_mclk;
  logic        next_bclk;
  logic        next_fs;

  assign divisor      = {div_high[3:0], div_low};
  assign filter_shift = div_high[7:4];

  // Register writes; writes to the levels byte are ignored
  always_comb begin
    next_ctrl     = ctrl;
    next_cts      = cts;
    next_div_low  = div_low;
    next_div_high = div_high;
    if (reg_write) begin
      if (reg_addr == audio_clock_pkg::ADDR_CTRL) begin
        next_ctrl = audio_clock_pkg::audio_ctrl_t'(reg_wdata);
      end else if (reg_addr == audio_clock_pkg::ADDR_CTS_LOW) begin
        next_cts[7:0] = reg_wdata;
      end else if (reg_addr == audio_clock_pkg::ADDR_CTS_MID) begin
        next_cts[15:8] = reg_wdata;
      end else if (reg_addr == audio_clock_pkg::ADDR_CTS_HIGH) begin
        next_cts[23:16] = reg_wdata;
      end else if (reg_addr == audio_clock_pkg::ADDR_DIV_LOW) begin
        next_div_low[7:0] = reg_wdata;
      end else if (reg_addr == audio_clock_pkg::ADDR_DIV_MID) begin
        next_div_low[15:8] = reg_wdata;
      end else if (reg_addr == audio_clock_pkg::ADDR_DIV_HIGH) begin
        next_div_high = reg_wdata;
      end
    end
  end

  // Read mux; unmapped offsets and reserved bits read zero
  always_comb begin
    next_rdata = audio_clock_pkg::RESET_BYTE;
    if (reg_read) begin
      if (reg_addr == audio_clock_pkg::ADDR_CTRL) begin
        next_rdata = ctrl;
      end else if (reg_addr == audio_clock_pkg::ADDR_CTS_LOW) begin
        next_rdata = cts[7:0];
      end else if (reg_addr == audio_clock_pkg::ADDR_CTS_MID) begin
        next_rdata = cts[15:8];
      end else if (reg_addr == audio_clock_pkg::ADDR_CTS_HIGH) begin
        next_rdata = cts[23:16];
      end else if (reg_addr == audio_clock_pkg::ADDR_DIV_LOW) begin
        next_rdata = div_low[7:0];
      end else if (reg_addr == audio_clock_pkg::ADDR_DIV_MID) begin
        next_rdata = div_low[15:8];
      end else if (reg_addr == audio_clock_pkg::ADDR_DIV_HIGH) begin
        next_rdata = div_high;
      end else if (reg_addr == audio_clock_pkg::ADDR_LEVELS) begin
        next_rdata = {2'b00, fill_held};
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl            <= audio_clock_pkg::audio_ctrl_t'(
                           audio_clock_pkg::RESET_BYTE);
      cts             <= 24'h000000;
      div_low         <= 16'h0000;
      div_high        <= audio_clock_pkg::RESET_BYTE;
      reg_rdata       <= audio_clock_pkg::RESET_BYTE;
      reg_rdata_valid <= 1'b0;
      fill_held       <= 6'h00;
    end else begin
      ctrl            <= next_ctrl;
      cts             <= next_cts;
      div_low         <= next_div_low;
      div_high        <= next_div_high;
      reg_rdata       <= next_rdata;
      reg_rdata_valid <= reg_read;
      fill_held       <= fill;
    end
  end

  // Two-stage synchronisers; edges come from the second stage only
  for (genvar i = 0; i < 4; i++) begin : g_sync
    always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
        sync_first[i]  <= 1'b0;
        sync_second[i] <= 1'b0;
        sync_prev[i]   <= 1'b0;
      end else begin
        sync_first[i]  <= (i == 0) ? link_pll_vco_clock :
                          (i == 1) ? always_on_oscillator :
                          (i == 2) ? bit_clock_in : frame_sync_pin_in;
        sync_second[i] <= sync_first[i];
        sync_prev[i]   <= sync_second[i];
      end
    end
    assign pin_edge[i] = sync_second[i] && !sync_prev[i];
  end

  assign vco_edge            = pin_edge[0];
  assign osc_edge            = pin_edge[1];
  assign bclk_edge           = pin_edge[2];
  assign received_frame_sync = sync_second[3];

  // Cleaner reference: VCO divided by 8, 4, 2 or the oscillator
  always_comb begin
    case (ctrl.clean_div)
      2'b00:   div_limit = 3'h7;
      2'b01:   div_limit = 3'h3;
      default: div_limit = 3'h1;
    endcase
    if (ctrl.clean_div == 2'b11) begin
      source_tick = osc_edge;
    end else begin
      source_tick = vco_edge && (div_count == div_limit);
    end
    next_div_count = div_count;
    if (vco_edge) begin
      next_div_count = (div_count >= div_limit) ? 3'h0
                       : 3'(div_count + 3'h1);
    end
  end

  // Regeneration: VCO edges scaled by divisor over time stamp
  always_comb begin
    regen_on        = (cts != 24'h000000) && (divisor != 20'h00000);
    acc_sum         = 25'(acc + {5'h00, divisor});
    next_acc        = acc;
    next_regen_tick = 1'b0;
    if (!regen_on) begin
      next_acc = 25'h0000000;
    end else if (vco_edge) begin
      if (acc_sum >= {1'b0, cts}) begin
        next_acc        = 25'(acc_sum - {1'b0, cts});
        next_regen_tick = 1'b1;
      end else begin
        next_acc = acc_sum;
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_count  <= 3'h0;
      acc        <= 25'h0000000;
      regen_tick <= 1'b0;
    end else begin
      div_count  <= next_div_count;
      acc        <= next_acc;
      regen_tick <= next_regen_tick;
    end
  end

  // Raw event: regenerated clock, else own reference or pin
  assign raw_tick = regen_on ? regen_tick
                    : (ctrl.master ? source_tick : bclk_edge);
  assign mclk_tick = (ctrl.clean_mode != 2'b00) ? clean_tick
                     : raw_tick;

  clock_cleaner u_cleaner (
    .core_clk     (core_clk),
    .reset_n      (reset_n),
    .source_tick  (source_tick),
    .raw_tick     (raw_tick),
    .clean_mode   (ctrl.clean_mode),
    .filter_shift (filter_shift),
    .clean_tick   (clean_tick),
    .fill         (fill)
  );

  // Each master edge advances the dividers; cleared while a slave
  always_comb begin
    case (ctrl.mclk_ratio)
      2'b00:   mclk_limit = 3'h3;
      2'b01:   mclk_limit = 3'h1;
      2'b10:   mclk_limit = 3'h0;
      default: mclk_limit = 3'h7;
    endcase
    half_frame = ctrl.frame_32 ? audio_clock_pkg::HALF_FRAME_32
                 : audio_clock_pkg::HALF_FRAME_64;
    next_mclk       = audio_master_clock;
    next_bclk       = bit_clock_out;
    next_fs         = frame_sync_pin_out;
    next_mclk_count = mclk_count;
    next_bit_count  = bit_count;
    if (!ctrl.master) begin
      next_mclk       = 1'b0;
      next_bclk       = 1'b0;
      next_fs         = 1'b0;
      next_mclk_count = 3'h0;
      next_bit_count  = 6'h00;
    end else if (mclk_tick) begin
      next_mclk = !audio_master_clock;
      if (mclk_count >= mclk_limit) begin
        next_mclk_count = 3'h0;
        next_bclk       = !bit_clock_out;
        if (bit_clock_out) begin
          // Frame sync moves on falling bit clock edges
          if (bit_count >= half_frame) begin
            next_bit_count = 6'h00;
            next_fs        = !frame_sync_pin_out;
          end else begin
            next_bit_count = 6'(bit_count + 6'h01);
          end
        end
      end else begin
        next_mclk_count = 3'(mclk_count + 3'h1);
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      audio_master_clock <= 1'b0;
      bit_clock_out      <= 1'b0;
      frame_sync_pin_out <= 1'b0;
      mclk_count         <= 3'h0;
      bit_count          <= 6'h00;
    end else begin
      audio_master_clock <= next_mclk;
      bit_clock_out      <= next_bclk;
      frame_sync_pin_out <= next_fs;
      mclk_count         <= next_mclk_count;
      bit_count          <= next_bit_count;
    end
  end

  // Pins driven only in master mode
  assign bit_clock_oe_n      = !ctrl.master;
  assign frame_sync_pin_oe_n = !ctrl.master;

  sequence s_write_cts_low;
    reg_write && reg_addr == audio_clock_pkg::ADDR_CTS_LOW;
  endsequence

  sequence s_read_levels;
    reg_read && reg_addr == audio_clock_pkg::ADDR_LEVELS;
  endsequence

  a_slave_pins_released: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    !ctrl.master |-> bit_clock_oe_n && frame_sync_pin_oe_n)
    else $error("pins driven in slave mode");

  a_slave_outputs_quiet: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    !ctrl.master ##1 !ctrl.master |-> !bit_clock_out
    && !frame_sync_pin_out)
    else $error("clock outputs active in slave mode");

  a_cts_write_read: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    s_write_cts_low ##1 (reg_read && reg_addr
      == audio_clock_pkg::ADDR_CTS_LOW && !reg_write)
    |=> reg_rdata == $past(reg_wdata, 2))
    else $error("time stamp low byte not stored");

  a_regen_idle_zero: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    (cts == 24'h000000) ##1 (cts == 24'h000000) |-> !regen_tick)
    else $error("regeneration with zero time stamp");

  a_levels_read_back: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    s_read_levels |=> reg_rdata[7:6] == 2'b00
    && reg_rdata[5:0] == $past(fill_held) && reg_rdata_valid)
    else $error("levels byte wrong");

  a_fs_on_bit_wrap: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    (ctrl.master && mclk_tick && mclk_count >= mclk_limit
     && bit_clock_out && bit_count >= half_frame)
    |=> frame_sync_pin_out != $past(frame_sync_pin_out))
    else $error("frame sync missed its toggle");

  a_ratio_one_bclk: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    (ctrl.master && ctrl.mclk_ratio == 2'b10 && mclk_tick)
    |=> bit_clock_out != $past(bit_clock_out))
    else $error("bit clock did not follow ratio of one");

  a_osc_reference: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    (ctrl.clean_div == 2'b11) |-> source_tick == osc_edge)
    else $error("oscillator not selected");

endmodule // audio_clock_generator_cleaner

`default_nettype wire

// File: verification/audio_source_model.sv
/*
 * Far-side serial audio source: drives bit clock and frame sync.
 * Assumes the bench resolves each pin from the generator's output enable alone.
 */
`default_nettype none

module audio_source_model (
  input  wire logic enable,
  output logic      bclk,
  output logic      fs
);
  timeunit 1ns;
  timeprecision 1ps;
  int falls;

  // Frames only while enabled; bclk is driven low while disabled, fs keeps its level
  initial begin
    bclk = 1'b0;
    fs = 1'b0;
    falls = 0;
    forever begin
      #48;
      if (enable) begin
        bclk = ~bclk;
        falls += int'(!bclk);
        if (falls == 32) begin
          falls = 0;
          fs = ~fs;
        end
      end else begin
        bclk = 1'b0;
      end
    end
  end
endmodule // audio_source_model

`default_nettype wire

// File: verification/audio_clock_generator_cleaner_tb_top.sv
/*
 * Bench: register access, divider ratios, reference select,
 * regeneration, cleaning and pin direction.
 * Released pins are driven by the far-side source model.
 */
`default_nettype none

module audio_clock_generator_cleaner_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0]  RATIO [4] = '{8'h04, 8'h02, 8'h01, 8'h08};
  localparam logic [23:0] CTS_V [2] = '{24'h020000, 24'h000300};
  localparam logic [23:0] N_V   [2] = '{24'h010000, 24'h000100};
  logic       core_clk, reset_n, reg_write, reg_read, vco, osc;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic       rvalid, src_en, src_bclk, src_fs, bclk_out, bclk_oe_n;
  logic       fs_out, fs_oe_n, mclk, rx_fs, f0;
  logic       p_mclk, p_bclk, p_fs, p_vco, p_osc;
  int         err_total, checks_done, nb, nf;
  int         mpb, last_mpb, bpf, last_bpf, vpm, last_vpm, opm, last_opm;

  audio_source_model u_src (.enable(src_en), .bclk(src_bclk),
                            .fs(src_fs));

  audio_clock_generator_cleaner u_dut (
    .core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .reg_rdata_valid(rvalid),
    .link_pll_vco_clock(vco), .always_on_oscillator(osc),
    .bit_clock_in(bclk_oe_n ? src_bclk : bclk_out),
    .bit_clock_out(bclk_out), .bit_clock_oe_n(bclk_oe_n),
    .frame_sync_pin_in(fs_oe_n ? src_fs : fs_out),
    .frame_sync_pin_out(fs_out), .frame_sync_pin_oe_n(fs_oe_n),
    .audio_master_clock(mclk), .received_frame_sync(rx_fs));

  // Core clock, VCO at 25 MHz and oscillator at 12.5 MHz, offset
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  initial begin
    vco = 1'b0;
    #3;
    forever #20 vco = ~vco;
  end
  initial begin
    osc = 1'b0;
    #7;
    forever #40 osc = ~osc;
  end

  // Interval counters: reference edges per mclk toggle, mclk toggles
  // per bclk toggle, bclk falls per frame-sync toggle
  initial {p_mclk, p_bclk, p_fs, p_vco, p_osc} = 5'h00;
  always @(posedge core_clk) begin
    vpm += int'(!p_vco && vco);
    opm += int'(!p_osc && osc);
    mpb += int'(p_mclk != mclk);
    if (p_mclk != mclk) begin
      last_vpm = vpm;
      last_opm = opm;
      vpm = 0;
      opm = 0;
    end
    if (p_bclk != bclk_out) begin
      last_mpb = mpb;
      mpb = 0;
      nb++;
      bpf += int'(p_bclk);
    end
    if (p_fs != fs_out) begin
      last_bpf = bpf;
      bpf = 0;
      nf++;
    end
    {p_mclk, p_bclk, p_fs, p_vco, p_osc} = {mclk, bclk_out, fs_out, vco, osc};
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    if (err_total == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(posedge core_clk);
    #1;
    reg_write = 1'b0;
  endtask

  // Read answer comes a cycle later; wait is bounded in case it never does
  task automatic rd(input logic [7:0] a, input logic [7:0] exp,
                    input logic [7:0] mask = 8'hFF);
    int i;
    @(posedge core_clk);
    #1;
    reg_addr = a;
    reg_read = 1'b1;
    @(posedge core_clk);
    #1;
    reg_read = 1'b0;
    for (i = 0; i < 3 && rvalid !== 1'b1; i++) begin
      @(posedge core_clk);
      #1;
    end
    chk({7'h00, rvalid}, 8'h01);
    chk(reg_rdata & mask, exp);
  endtask

  // Bounded wait for k more toggles of a monitored output
  task automatic waitn(ref int cnt, input int k);
    int i, b0;
    b0 = cnt;
    for (i = 0; i < 20000 && cnt < b0 + k; i++) @(posedge core_clk);
    if (cnt < b0 + k) begin
      err_total++;
      final_report();
    end
  endtask

  initial begin
    {reset_n, reg_write, reg_read, src_en} = 4'h0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    err_total = 0;
    checks_done = 0;
    repeat (2) @(posedge core_clk);
    #1;
    reset_n = 1'b1;
    chk({6'h00, bclk_oe_n, fs_oe_n}, 8'h03);
    for (int a = 8'h30; a <= 8'h37; a++) rd(8'(a), 8'h00);
    // Byte registers hold what is written; levels and holes read zero
    for (int a = 8'h31; a <= 8'h36; a++) wr(8'(a), 8'(a + 8'h90));
    for (int a = 8'h31; a <= 8'h36; a++) rd(8'(a), 8'(a + 8'h90));
    wr(8'h37, 8'hFF);
    rd(8'h37, 8'h00);
    rd(8'h40, 8'h00);
    // Write then read on back-to-back edges
    @(posedge core_clk);
    #1;
    {reg_addr, reg_wdata, reg_write} = {8'h31, 8'h5A, 1'b1};
    @(posedge core_clk);
    #1;
    {reg_write, reg_read} = 2'b01;
    @(posedge core_clk);
    #1;
    reg_read = 1'b0;
    chk(reg_rdata, 8'h5A);
    for (int a = 8'h31; a <= 8'h36; a++) wr(8'(a), 8'h00);
    // Master-to-bit ratio per code, oscillator reference
    for (int c = 0; c < 4; c++) begin
      wr(8'h30, {1'b0, 2'(c), 2'h3, 2'h0, 1'b1});
      waitn(nb, 3);
      chk(8'(last_mpb), RATIO[c]);
      chk(8'(last_opm), 8'h01);
    end
    chk({6'h00, bclk_oe_n, fs_oe_n}, 8'h00);
    // Bit clocks per frame: 32 falls per half frame, then 16
    for (int f = 0; f < 2; f++) begin
      wr(8'h30, {1'(f), 2'h2, 2'h3, 2'h0, 1'b1});
      waitn(nf, 3);
      chk(8'(last_bpf), f ? 8'h10 : 8'h20);
    end
    // VCO divided by 8, 4 and 2
    for (int c = 0; c < 3; c++) begin
      wr(8'h30, {1'b0, 2'h2, 2'(c), 2'h0, 1'b1});
      waitn(nb, 3);
      chk(8'(last_vpm), 8'h08 >> c);
    end
    // Regenerated clock: VCO edges per tick is time stamp over divisor
    for (int k = 0; k < 2; k++) begin
      // Zero time stamp first so the accumulator restarts empty
      for (int a = 8'h31; a <= 8'h36; a++) wr(8'(a), 8'h00);
      for (int b = 0; b < 3; b++) begin
        wr(8'(8'h31 + b), CTS_V[k][8*b +: 8]);
        wr(8'(8'h34 + b), N_V[k][8*b +: 8]);
      end
      waitn(nb, 3);
      chk(8'(last_vpm), 8'(k + 2));
    end
    for (int a = 8'h31; a <= 8'h36; a++) wr(8'(a), 8'h00);
    // Cleaning on with a filter shift: clocks keep coming
    wr(8'h36, 8'h20);
    wr(8'h30, 8'h53);
    waitn(nb, 3);
    rd(8'h37, 8'h00, 8'hC0);
    // Slave: pins released, far side frames received
    wr(8'h30, 8'h00);
    src_en = 1'b1;
    f0 = src_fs;
    for (int i = 0; i < 10000 && src_fs === f0; i++) @(posedge core_clk);
    if (src_fs === f0) begin
      err_total++;
      final_report();
    end
    repeat (4) @(posedge core_clk);
    #1;
    chk({7'h00, rx_fs}, {7'h00, src_fs});
    chk({4'h0, bclk_oe_n, fs_oe_n, bclk_out, fs_out}, 8'h0C);
    final_report();
  end
endmodule // audio_clock_generator_cleaner_tb_top

`default_nettype wire
